// file: verilog/iatw_cfg.svh
// Constants for the integer datapath: opcodes, flag positions, register offsets.
`ifndef IATW_CFG_SVH
`define IATW_CFG_SVH
`define IATW_OP_TADD 6'h20
`define IATW_OP_TSUB 6'h21
`define IATW_OP_TADDTV 6'h22
`define IATW_OP_TSUBTV 6'h23
`define IATW_OP_MULS 6'h24
`define IATW_OP_SLL 6'h25
`define IATW_OP_SRL 6'h26
`define IATW_OP_SRA 6'h27
`define IATW_OP_SAVE 6'h3c
`define IATW_OP_RESTORE 6'h3d
`define IATW_LOG_AND 3'h1
`define IATW_LOG_OR 3'h2
`define IATW_LOG_XOR 3'h3
`define IATW_LOG_AND_NOT_OP 3'h5
`define IATW_LOG_ORN 3'h6
`define IATW_LOG_XNOR 3'h7
`define IATW_CC_N 3
`define IATW_CC_Z 2
`define IATW_CC_V 1
`define IATW_CC_C 0
`define IATW_REG_Y 4'h0
`define IATW_REG_CWP 4'h4
`define IATW_REG_WIM 4'h8
`define IATW_REG_STAT 4'hc
`define IATW_Y_RST 32'h0000_0000
`define IATW_CWP_RST 3'h0
`define IATW_WIM_RST 7'h00
`endif

// file: verilog/iatw_pkg.sv
// Types shared by the integer datapath modules.
package iatw_pkg;
  typedef enum logic [2:0] {
    OPC_NONE,
    OPC_TAG,
    OPC_MUL,
    OPC_LOGIC,
    OPC_SHIFT,
    OPC_WIN
  } iatw_opclass_type;
endpackage

// file: verilog/iatw_adder.sv
// 32-bit adder/subtractor with integer condition flags.
`timescale 1ns/1ps
module iatw_adder (
  // Operands
  input wire logic [31:0] a_i,
  input wire logic [31:0] b_i,
  input wire logic sub_i,
  // Result and flags
  output logic [31:0] sum_o,
  output logic n_o,
  output logic z_o,
  output logic v_o,
  output logic c_o
);
  logic [32:0] full;
  logic [31:0] b_eff;

  always_comb begin
    b_eff = sub_i ? ~b_i : b_i;
    full = {1'b0, a_i} + {1'b0, b_eff} + {32'h0000_0000, sub_i};
    sum_o = full[31:0];
    n_o = full[31];
    z_o = (full[31:0] == 32'h0000_0000);
    // Overflow when both inputs share a sign the result lacks.
    v_o = (a_i[31] == b_eff[31]) && (full[31] != a_i[31]);
    // A subtract reports borrow, the inverse of the carry out.
    c_o = sub_i ? ~full[32] : full[32];
  end
endmodule

// file: verilog/iatw_shifter.sv
// Logarithmic barrel shifter for the logical and arithmetic shifts.
`timescale 1ns/1ps
module iatw_shifter #(
  parameter int WIDTH = 32,
  parameter int CNT_W = 5
) (
  // Operand and control
  input wire logic [WIDTH-1:0] data_i,
  input wire logic [CNT_W-1:0] count_i,
  input wire logic right_i,
  input wire logic arith_i,
  // Result
  output logic [WIDTH-1:0] data_o
);
  logic [WIDTH-1:0] stage [0:CNT_W];
  logic fill;

  assign fill = right_i & arith_i & data_i[WIDTH-1];
  assign stage[0] = data_i;

  genvar k;
  generate
    for (k = 0; k < CNT_W; k++) begin : g_stage
      localparam int SH = 1 << k;
      assign stage[k+1] = !count_i[k] ? stage[k] :
        right_i ? {{SH{fill}}, stage[k][WIDTH-1:SH]} :
        {stage[k][WIDTH-1-SH:0], {SH{1'b0}}};
    end
  endgenerate

  assign data_o = stage[CNT_W];
endmodule

// file: verilog/iatw_alu.sv
// Integer datapath: tagged arithmetic, multiply step, logic, shifts, window save/restore.
//
// Contract
// - Tagged add/sub of first source and operand.
// - Nonzero tag or overflow sets overflow flag.
// - Trapping overflow traps, keeps destination and codes.
// - Trapping no-overflow writes result, codes, clears overflow.
// - Non-trapping sets/clears overflow, writes everything.
// - Multiply step shifts partial product, top n^v.
// - Adds multiplicand when multiplier bit zero set.
// - Multiply step writes sum, sets codes.
// - Multiplier shifts right, top gets product lsb.
// - Six bitwise operations on first source and operand.
// - Code-setting logic variants update all codes.
// - Shift count is low five operand bits.
// - Zero or sign fill; zero count no shift.
// - Shifts write result, keep condition codes.
// - Save decrements pointer mod 7, mask check.
// - Restore increments pointer mod 7, mask check.
// - Untrapped save/restore adds, writes through new window.
// - Operand is register or sign-extended 13-bit immediate.
`timescale 1ns/1ps
`include "iatw_cfg.svh"
module iatw_alu #(
  parameter int NWIN = 7
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Instruction issue
  input wire logic valid_i,
  input wire logic [5:0] op3_i,
  input wire logic imm_flag_i,
  input wire logic [31:0] first_source_reg_i,
  input wire logic [31:0] second_source_reg_i,
  input wire logic [12:0] signed_immediate_i,
  input wire logic [3:0] icc_i,
  // Instruction results
  output logic done_o,
  output logic [31:0] result_o,
  output logic rd_we_o,
  output logic [2:0] rd_window_o,
  output logic [3:0] icc_o,
  output logic icc_we_o,
  output logic tag_trap_o,
  output logic window_overflow_trap_o,
  output logic window_underflow_trap_o,
  output logic [2:0] current_window_pointer_o,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o
);
  import iatw_pkg::*;

  localparam logic [2:0] CWP_MAX = 3'(NWIN - 1);

  // State.
  logic [31:0] y_r, y_nxt;
  logic [2:0] cwp_r, cwp_nxt;
  logic [NWIN-1:0] wim_r, wim_nxt;
  logic done_r, done_nxt;
  logic [31:0] result_r, result_nxt;
  logic rd_we_r, rd_we_nxt;
  logic [2:0] rd_win_r, rd_win_nxt;
  logic [3:0] icc_r, icc_nxt;
  logic icc_we_r, icc_we_nxt;
  logic tag_trap_r, tag_trap_nxt;
  logic wovf_r, wovf_nxt;
  logic wunf_r, wunf_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  // Operand path.
  iatw_opclass_type opclass;
  logic [31:0] simm_ext, op2;
  logic [31:0] add_a, add_b, add_sum;
  logic add_sub, add_n, add_z, add_v, add_c;
  logic [31:0] log_res, shift_res;
  logic tag_ovf, tag_trapping;
  logic [2:0] cwp_dec, cwp_inc;

  assign simm_ext = {{19{signed_immediate_i[12]}}, signed_immediate_i};
  assign op2 = imm_flag_i ? simm_ext : second_source_reg_i;

  always_comb begin
    case (op3_i)
      `IATW_OP_TADD, `IATW_OP_TSUB, `IATW_OP_TADDTV, `IATW_OP_TSUBTV: opclass = OPC_TAG;
      `IATW_OP_MULS: opclass = OPC_MUL;
      `IATW_OP_SLL, `IATW_OP_SRL, `IATW_OP_SRA: opclass = OPC_SHIFT;
      `IATW_OP_SAVE, `IATW_OP_RESTORE: opclass = OPC_WIN;
      default: begin
        // Logic opcodes: bit 5 and bit 3 clear, low bits neither zero nor four (subtract).
        if (!op3_i[5] && !op3_i[3] && op3_i[2:0] != 3'h0 && op3_i[2:0] != 3'h4) begin
          opclass = OPC_LOGIC;
        end else begin
          opclass = OPC_NONE;
        end
      end
    endcase
  end

  // One adder serves tagged, multiply-step and window arithmetic.
  always_comb begin
    add_a = first_source_reg_i;
    add_b = op2;
    add_sub = 1'b0;
    case (opclass)
      OPC_TAG: begin
        add_sub = op3_i[0];
      end
      OPC_MUL: begin
        add_a = {icc_i[`IATW_CC_N] ^ icc_i[`IATW_CC_V], first_source_reg_i[31:1]};
        add_b = y_r[0] ? op2 : 32'h0000_0000;
      end
      default: begin
        add_sub = 1'b0;
      end
    endcase
  end

  iatw_adder u_adder (
    .a_i(add_a),
    .b_i(add_b),
    .sub_i(add_sub),
    .sum_o(add_sum),
    .n_o(add_n),
    .z_o(add_z),
    .v_o(add_v),
    .c_o(add_c)
  );

  // Shift count is the low five bits of the chosen operand.
  iatw_shifter #(
    .WIDTH(32),
    .CNT_W(5)
  ) u_shifter (
    .data_i(first_source_reg_i),
    .count_i(op2[4:0]),
    .right_i(op3_i != `IATW_OP_SLL),
    .arith_i(op3_i == `IATW_OP_SRA),
    .data_o(shift_res)
  );

  always_comb begin
    case (op3_i[2:0])
      `IATW_LOG_AND: log_res = first_source_reg_i & op2;
      `IATW_LOG_AND_NOT_OP: log_res = first_source_reg_i & ~op2;
      `IATW_LOG_OR: log_res = first_source_reg_i | op2;
      `IATW_LOG_ORN: log_res = first_source_reg_i | ~op2;
      `IATW_LOG_XOR: log_res = first_source_reg_i ^ op2;
      `IATW_LOG_XNOR: log_res = ~(first_source_reg_i ^ op2);
      default: log_res = 32'h0000_0000;
    endcase
  end

  assign tag_ovf = (first_source_reg_i[1:0] != 2'h0) || (op2[1:0] != 2'h0) || add_v;
  assign tag_trapping = op3_i[1];
  // Window arithmetic wraps over the seven windows.
  assign cwp_dec = (cwp_r == 3'h0) ? CWP_MAX : cwp_r - 3'h1;
  assign cwp_inc = (cwp_r == CWP_MAX) ? 3'h0 : cwp_r + 3'h1;

  always_comb begin
    y_nxt = y_r;
    cwp_nxt = cwp_r;
    wim_nxt = wim_r;
    done_nxt = valid_i;
    result_nxt = result_r;
    rd_we_nxt = 1'b0;
    rd_win_nxt = cwp_r;
    icc_nxt = icc_r;
    icc_we_nxt = 1'b0;
    tag_trap_nxt = 1'b0;
    wovf_nxt = 1'b0;
    wunf_nxt = 1'b0;
    rdata_nxt = 32'h0000_0000;
    // Software writes first, so a same-cycle instruction update wins.
    if (reg_wr_i) begin
      case (reg_addr_i)
        `IATW_REG_Y: y_nxt = reg_wdata_i;
        `IATW_REG_CWP: cwp_nxt = (reg_wdata_i[2:0] > CWP_MAX) ? CWP_MAX : reg_wdata_i[2:0];
        `IATW_REG_WIM: wim_nxt = reg_wdata_i[NWIN-1:0];
        default: y_nxt = y_r;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `IATW_REG_Y: rdata_nxt = y_r;
        `IATW_REG_CWP: rdata_nxt = {29'h0000_0000, cwp_r};
        `IATW_REG_WIM: rdata_nxt = {{(32-NWIN){1'b0}}, wim_r};
        `IATW_REG_STAT: rdata_nxt = {29'h0000_0000, wunf_r, wovf_r, tag_trap_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    if (valid_i) begin
      case (opclass)
        OPC_TAG: begin
          if (tag_trapping && tag_ovf) begin
            tag_trap_nxt = 1'b1;
          end else begin
            result_nxt = add_sum;
            rd_we_nxt = 1'b1;
            icc_we_nxt = 1'b1;
            // Trapping form only gets here without overflow, so this is zero.
            icc_nxt = {add_n, add_z, tag_ovf, add_c};
          end
        end
        OPC_MUL: begin
          result_nxt = add_sum;
          rd_we_nxt = 1'b1;
          icc_we_nxt = 1'b1;
          icc_nxt = {add_n, add_z, add_v, add_c};
          y_nxt = {first_source_reg_i[0], y_r[31:1]};
        end
        OPC_LOGIC: begin
          result_nxt = log_res;
          rd_we_nxt = 1'b1;
          // Only the op3 bit 4 variants touch the codes.
          icc_we_nxt = op3_i[4];
          icc_nxt = op3_i[4] ? {log_res[31], log_res == 32'h0000_0000, 2'b00} : icc_r;
        end
        OPC_SHIFT: begin
          result_nxt = shift_res;
          rd_we_nxt = 1'b1;
        end
        OPC_WIN: begin
          if (op3_i == `IATW_OP_SAVE) begin
            if (wim_r[cwp_dec]) begin
              wovf_nxt = 1'b1;
            end else begin
              cwp_nxt = cwp_dec;
            end
          end else begin
            if (wim_r[cwp_inc]) begin
              wunf_nxt = 1'b1;
            end else begin
              cwp_nxt = cwp_inc;
            end
          end
          // Operands came in through the old window; the sum goes to the new one.
          if (!wovf_nxt && !wunf_nxt) begin
            result_nxt = add_sum;
            rd_we_nxt = 1'b1;
            rd_win_nxt = cwp_nxt;
          end
        end
        default: begin
          // Unknown opcodes complete with no effect.
          rd_we_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      y_r <= `IATW_Y_RST;
      cwp_r <= `IATW_CWP_RST;
      wim_r <= NWIN'(`IATW_WIM_RST);
      done_r <= 1'b0;
      result_r <= 32'h0000_0000;
      rd_we_r <= 1'b0;
      rd_win_r <= 3'h0;
      icc_r <= 4'h0;
      icc_we_r <= 1'b0;
      tag_trap_r <= 1'b0;
      wovf_r <= 1'b0;
      wunf_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      y_r <= y_nxt;
      cwp_r <= cwp_nxt;
      wim_r <= wim_nxt;
      done_r <= done_nxt;
      result_r <= result_nxt;
      rd_we_r <= rd_we_nxt;
      rd_win_r <= rd_win_nxt;
      icc_r <= icc_nxt;
      icc_we_r <= icc_we_nxt;
      tag_trap_r <= tag_trap_nxt;
      wovf_r <= wovf_nxt;
      wunf_r <= wunf_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign done_o = done_r;
  assign result_o = result_r;
  assign rd_we_o = rd_we_r;
  assign rd_window_o = rd_win_r;
  assign icc_o = icc_r;
  assign icc_we_o = icc_we_r;
  assign tag_trap_o = tag_trap_r;
  assign window_overflow_trap_o = wovf_r;
  assign window_underflow_trap_o = wunf_r;
  assign current_window_pointer_o = cwp_r;
  assign reg_rdata_o = rdata_r;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_issue_tag;
    valid_i && opclass == OPC_TAG;
  endsequence

  sequence s_quiet_done;
    done_o && !rd_we_o && !icc_we_o;
  endsequence

  a_tag_trap_quiet: assert property (
    s_issue_tag ##0 (tag_trapping && tag_ovf) |=> s_quiet_done ##0 tag_trap_o)
    else $error("trapping tagged op changed state");

  a_tag_v_tag: assert property (
    s_issue_tag ##0 (!tag_trapping && first_source_reg_i[1:0] != 2'h0)
    |=> icc_we_o && icc_o[`IATW_CC_V])
    else $error("nonzero tag did not set overflow");

  a_tagtv_v_zero: assert property (
    s_issue_tag ##0 tag_trapping |=> tag_trap_o || (icc_we_o && !icc_o[`IATW_CC_V]))
    else $error("trapping tagged op left overflow set");

  a_tag_sum: assert property (
    s_issue_tag ##0 !tag_trapping |=> rd_we_o && result_o ==
    ($past(op3_i[0]) ? $past(first_source_reg_i) - $past(op2)
                     : $past(first_source_reg_i) + $past(op2)))
    else $error("tagged result wrong");

  a_mul_y_shift: assert property (
    valid_i && opclass == OPC_MUL |=>
    y_r == {$past(first_source_reg_i[0]), $past(y_r[31:1])})
    else $error("multiplier register not shifted");

  a_mul_zero_add: assert property (
    valid_i && opclass == OPC_MUL && !y_r[0] |=>
    result_o == {$past(icc_i[3] ^ icc_i[1]), $past(first_source_reg_i[31:1])})
    else $error("multiply step added with clear multiplier bit");

  a_logic_nocc: assert property (
    valid_i && opclass == OPC_LOGIC && !op3_i[4] |=> rd_we_o && !icc_we_o)
    else $error("plain logic op wrote codes");

  a_shift_nocc: assert property (
    valid_i && opclass == OPC_SHIFT |=> rd_we_o && !icc_we_o && icc_o == $past(icc_o))
    else $error("shift changed codes");

  a_sra_fill: assert property (
    valid_i && op3_i == `IATW_OP_SRA && first_source_reg_i[31] && op2[4:0] != 5'h0
    |=> result_o[31] && result_o[30])
    else $error("arithmetic shift lost sign fill");

  a_save_commit: assert property (
    valid_i && op3_i == `IATW_OP_SAVE && !wim_r[cwp_dec] |=>
    cwp_r == $past(cwp_dec) && rd_window_o == cwp_r && rd_we_o)
    else $error("save did not commit new window");

  a_window_trap_hold: assert property (
    (window_overflow_trap_o || window_underflow_trap_o) |->
    !rd_we_o && !icc_we_o && cwp_r == $past(cwp_r))
    else $error("window trap changed state");
endmodule

// file: verification/iatw_far_model.sv
// Condition-code holder of the decode side, forwarding fresh codes to the datapath.
`timescale 1ns/1ps
module iatw_far_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Codes from the datapath
  input wire logic icc_we_i,
  input wire logic [3:0] icc_new_i,
  // Codes to the datapath
  output logic [3:0] icc_o
);
  logic [3:0] icc_r;
  logic [3:0] icc_nxt;

  always_comb begin
    icc_nxt = icc_we_i ? icc_new_i : icc_r;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      icc_r <= 4'h0;
    end else begin
      icc_r <= icc_nxt;
    end
  end

  // Forwarding matters: the next instruction is taken before the register updates.
  assign icc_o = icc_nxt;
endmodule

// file: verification/test_integer_alu_tag_mulstep_shift_window.sv
// Self-checking bench for the integer datapath against a behavioural model.
`timescale 1ns/1ps
module test_integer_alu_tag_mulstep_shift_window;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic valid_i = 1'b0;
  logic [5:0] op3_i = 6'h00;
  logic imm_flag_i = 1'b0;
  logic [31:0] src1 = 32'h0;
  logic [31:0] src2 = 32'h0;
  logic [12:0] simm = 13'h0;
  logic [3:0] icc_in;
  logic done_o, rd_we_o, icc_we_o, tag_trap_o, wo_o, wu_o;
  logic [31:0] result_o, reg_rdata_o;
  logic [2:0] rd_window_o, cwp_o;
  logic [3:0] icc_o;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] m_y = 32'h0;
  logic [2:0] m_cwp = 3'h0;
  logic [6:0] m_wim = 7'h0;
  logic [3:0] m_icc = 4'h0;
  logic [31:0] rnd = 32'h0f8380cd;
  logic [31:0] x1, x2;
  logic [5:0] ops [26] = '{6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h3c,
    6'h3d, 6'h01, 6'h02, 6'h03, 6'h05, 6'h06, 6'h07, 6'h11, 6'h12, 6'h13, 6'h15, 6'h16,
    6'h17, 6'h08, 6'h24, 6'h04, 6'h14};
  int errors = 0;
  int tests_run = 0;

  iatw_alu i_iatw_alu (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .valid_i(valid_i),
    .op3_i(op3_i), .imm_flag_i(imm_flag_i), .first_source_reg_i(src1),
    .second_source_reg_i(src2), .signed_immediate_i(simm), .icc_i(icc_in), .done_o(done_o),
    .result_o(result_o), .rd_we_o(rd_we_o), .rd_window_o(rd_window_o), .icc_o(icc_o),
    .icc_we_o(icc_we_o), .tag_trap_o(tag_trap_o), .window_overflow_trap_o(wo_o),
    .window_underflow_trap_o(wu_o), .current_window_pointer_o(cwp_o),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));

  iatw_far_model i_iatw_far_model (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .icc_we_i(icc_we_o), .icc_new_i(icc_o), .icc_o(icc_in));

  always #4 sys_clk_i = ~sys_clk_i;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One register access; the read data are looked at in the cycle after the strobe.
  task automatic reg_op(input logic w, input logic [3:0] ad, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    if (!w) chk("reg_rdata", d, reg_rdata_o);
    else if (ad == 4'h0) m_y = d;
    else if (ad == 4'h4) m_cwp = d[2:0] > 3'h6 ? 3'h6 : d[2:0];
    else if (ad == 4'h8) m_wim = d[6:0];
  endtask

  task automatic run(input logic [5:0] op, input logic [31:0] a, input logic [31:0] b,
                     input logic [12:0] s, input logic i);
    logic [31:0] o2, r, sa, ad;
    logic [32:0] w;
    logic [3:0] cc;
    logic [2:0] nw, win;
    logic we, cwe, tt, wo, wu, v;
    o2 = i ? {{19{s[12]}}, s} : b;
    {we, cwe, tt, wo, wu} = 5'h00;
    r = 32'h0;
    cc = m_icc;
    win = m_cwp;
    if (op[5:2] == 4'h8) begin
      w = op[0] ? {1'b0, a} - {1'b0, o2} : {1'b0, a} + {1'b0, o2};
      r = w[31:0];
      v = |{a[1:0], o2[1:0]} | (op[0] ? a[31] != o2[31] : a[31] == o2[31]) & (r[31] != a[31]);
      cc = {r[31], r == 32'h0, v, w[32]};
      tt = op[1] & v;
      we = !tt;
      cwe = !tt;
    end else if (op == 6'h24) begin
      sa = {m_icc[3] ^ m_icc[1], a[31:1]};
      ad = m_y[0] ? o2 : 32'h0;
      w = {1'b0, sa} + {1'b0, ad};
      r = w[31:0];
      cc = {r[31], r == 32'h0, (sa[31] == ad[31]) & (r[31] != sa[31]), w[32]};
      we = 1'b1;
      cwe = 1'b1;
      m_y = {a[0], m_y[31:1]};
    end else if (op[5:2] == 4'h9) begin
      r = op[1:0] == 2'h1 ? a << o2[4:0] : op[1:0] == 2'h2 ? a >> o2[4:0] :
          32'($signed(a) >>> o2[4:0]);
      we = 1'b1;
    end else if (op[5:1] == 5'h1e) begin
      nw = op[0] ? (m_cwp == 3'h6 ? 3'h0 : m_cwp + 3'h1) : (m_cwp == 3'h0 ? 3'h6 : m_cwp - 3'h1);
      wo = m_wim[nw] & !op[0];
      wu = m_wim[nw] & op[0];
      if (!m_wim[nw]) begin
        r = a + o2;
        we = 1'b1;
        m_cwp = nw;
        win = nw;
      end
    end else if (!op[5] && !op[3] && op[2:0] != 3'h0 && op[2:0] != 3'h4) begin
      o2 = op[2] ? ~o2 : o2;
      r = op[1:0] == 2'h1 ? a & o2 : op[1:0] == 2'h2 ? a | o2 : a ^ o2;
      we = 1'b1;
      cwe = op[4];
      cc = {r[31], r == 32'h0, 2'b00};
    end
    if (cwe) m_icc = cc;
    @(posedge sys_clk_i);
    valid_i <= 1'b1;
    op3_i <= op;
    src1 <= a;
    src2 <= b;
    simm <= s;
    imm_flag_i <= i;
    @(posedge sys_clk_i);
    valid_i <= 1'b0;
    @(negedge sys_clk_i);
    chk("done", 32'h1, {31'h0, done_o});
    chk("rd_we", {31'h0, we}, {31'h0, rd_we_o});
    chk("icc_we", {31'h0, cwe}, {31'h0, icc_we_o});
    chk("tag_trap", {31'h0, tt}, {31'h0, tag_trap_o});
    chk("win_over", {31'h0, wo}, {31'h0, wo_o});
    chk("win_under", {31'h0, wu}, {31'h0, wu_o});
    chk("cwp", {29'h0, m_cwp}, {29'h0, cwp_o});
    if (we) chk("result", r, result_o);
    if (we) chk("rd_window", {29'h0, win}, {29'h0, rd_window_o});
    if (cwe) chk("icc", {28'h0, cc}, {28'h0, icc_o});
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk_i);
    errors++;
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    reg_op(1'b0, 4'h0, 32'h0);
    reg_op(1'b0, 4'h4, 32'h0);
    reg_op(1'b0, 4'h8, 32'h0);
    reg_op(1'b0, 4'hc, 32'h0);
    reg_op(1'b0, 4'h2, 32'h0);
    reg_op(1'b1, 4'h4, 32'h7);
    reg_op(1'b0, 4'h4, 32'h6);
    run(6'h20, 32'h4, 32'h8, 13'h0, 1'b0);
    run(6'h22, 32'h7fff_fffc, 32'h4, 13'h0, 1'b0);
    run(6'h23, 32'h8, 32'h0, 13'h1ffc, 1'b1);
    run(6'h27, 32'h8000_0000, 32'hffff_ffe0, 13'h0, 1'b0);
    run(6'h27, 32'h8000_0000, 32'h0, 13'h1f, 1'b1);
    for (int k = 0; k < 300; k++) begin
      rnd = lfsr(rnd);
      if (k % 20 == 0) reg_op(1'b1, 4'h8, {25'h0, rnd[6:0] & rnd[13:7]});
      if (k % 20 == 19) reg_op(1'b0, 4'h0, m_y);
      if (k % 20 == 10) reg_op(1'b0, 4'h8, {25'h0, m_wim});
      x1 = lfsr(rnd);
      x2 = lfsr(x1);
      x1[1:0] = x1[1:0] & {2{rnd[10]}};
      x2[1:0] = x2[1:0] & {2{rnd[11]}};
      run(ops[rnd[9:5] % 26], x1, x2, rnd[25:13], rnd[12]);
      rnd = x2;
    end
    end_of_test();
  end
endmodule
